// ---- rtl/pph_pkg.sv ----
// Package: register map, field positions and reset values for the handshake ports
package pph_pkg;
    localparam int          DATA_W          = 8;
    localparam int          FIFO_DEPTH      = 32;
    localparam int          SYNC_W          = 20;

    localparam logic [3:0]  REG_PORT_B      = 4'h0;
    localparam logic [3:0]  REG_PORT_A      = 4'h1;
    localparam logic [3:0]  REG_DIR_B       = 4'h2;
    localparam logic [3:0]  REG_DIR_A       = 4'h3;
    localparam logic [3:0]  REG_AUX_CTRL    = 4'hB;
    localparam logic [3:0]  REG_LINE_CTRL   = 4'hC;
    localparam logic [3:0]  REG_FLAGS       = 4'hD;
    localparam logic [3:0]  REG_PORT_A_NH   = 4'hF;

    // Line control fields
    localparam int          LC_A1_EDGE      = 0;
    localparam int          LC_A2_LSB       = 1;
    localparam int          LC_B1_EDGE      = 4;
    localparam int          LC_B2_LSB       = 5;

    // Auxiliary control latch enables
    localparam int          AUX_LATCH_A     = 0;
    localparam int          AUX_LATCH_B     = 1;

    // Flag register bit positions
    localparam int          FLG_A2          = 0;
    localparam int          FLG_A1          = 1;
    localparam int          FLG_B2          = 3;
    localparam int          FLG_B1          = 4;
    localparam logic [7:0]  FLG_MASK        = 8'h1B;

    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam int          PULSE_CYCLES    = 1;

    typedef enum logic [2:0] {
        PPH_IN_NEG, PPH_IND_NEG, PPH_IN_POS, PPH_IND_POS,
        PPH_OUT_HS, PPH_OUT_PULSE, PPH_OUT_LOW, PPH_OUT_HIGH
    } pph_ctl2_mode_t;
endpackage : pph_pkg

// ---- rtl/pph_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pph_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = ce ? d : meta_reg;
        q_next    = ce ? meta_reg : q;
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    meta_reg[i] <= 1'b0;
                    q[i]        <= 1'b0;
                end else begin
                    meta_reg[i] <= meta_next[i];
                    q[i]        <= q_next[i];
                end
            end
        end
    endgenerate
endmodule : pph_sync

// ---- rtl/pph_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pph_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] wr_next;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push;
    logic          pop;

    always_comb begin
        in_ready  = (cnt_reg != (AW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        out_data  = mem[rd_reg];
        push      = ce && in_valid && in_ready;
        pop       = ce && out_valid && out_ready;
        wr_next   = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next   = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage carries no reset; contents are qualified by the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule : pph_fifo

// ---- rtl/pph_ports.sv ----
// Two handshaked 8-bit peripheral ports with direction, latching and control lines
// Functional notes
// - Direction bit one drives line, zero floats
// - Output line follows its output register bit
// - Writes to input lines stored, not driven
// - Unlatched port A read returns live lines
// - Port A captures lines on control-one edge
// - Latched port A goes transparent after read
// - Port B output lines read register value
// - Latched port B inputs read captured level
// - Port A output lines read actual pins
// - Register 0 is port B, 1 port A
// - Port A read/write handshake, port B write
// - Port A data-ready edge sets its flag
// - Data-taken drops on access, rises on ready
// - Data-taken edge sets flag, clears data-ready
// - Port B line-two field bits 7:5, input codes
// - Codes 100-111 select output modes
// - Independent input flags cleared only by flag write
// - Edge-select zero negative, one positive
// - Auxiliary bits enable latching per port
// - Register 15 is port A without handshake
`timescale 1ns/10ps
module pph_ports (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       chip_sel,
    input  wire logic [3:0] reg_sel,
    input  wire logic       rd_stb,
    input  wire logic       wr_stb,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic [7:0] port_a_lines_i,
    output logic      [7:0] port_a_lines_o,
    output logic      [7:0] port_a_lines_oe,
    input  wire logic [7:0] port_b_lines_i,
    output logic      [7:0] port_b_lines_o,
    output logic      [7:0] port_b_lines_oe,
    input  wire logic       port_a_ctrl_one,
    input  wire logic       port_a_ctrl_two_i,
    output logic            port_a_ctrl_two_o,
    output logic            port_a_ctrl_two_oe,
    input  wire logic       port_b_ctrl_one,
    input  wire logic       port_b_ctrl_two_i,
    output logic            port_b_ctrl_two_o,
    output logic            port_b_ctrl_two_oe,
    output logic      [7:0] interrupt_flags,
    output logic            capture_ready,
    output logic            capture_valid,
    input  wire logic       capture_take,
    output logic      [7:0] capture_data
);
    logic [19:0] sync_q;
    logic [7:0]  pin_a;
    logic [7:0]  pin_b;
    logic        a1_s;
    logic        a2_s;
    logic        b1_s;
    logic        b2_s;

    pph_sync #(.W(pph_pkg::SYNC_W)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .d      ({port_a_lines_i, port_b_lines_i, port_a_ctrl_one, port_a_ctrl_two_i,
                  port_b_ctrl_one, port_b_ctrl_two_i}),
        .q      (sync_q)
    );

    assign pin_a = sync_q[19:12];
    assign pin_b = sync_q[11:4];
    assign a1_s = sync_q[3];
    assign a2_s = sync_q[2];
    assign b1_s = sync_q[1];
    assign b2_s = sync_q[0];

    // Register state
    logic [7:0] out_a_reg, out_a_next;
    logic [7:0] out_b_reg, out_b_next;
    logic [7:0] dir_a_reg, dir_a_next;
    logic [7:0] dir_b_reg, dir_b_next;
    logic [7:0] aux_reg, aux_next;
    logic [7:0] ctl_reg, ctl_next;
    logic [7:0] flag_reg, flag_next;
    logic [7:0] in_a_reg, in_a_next;
    logic [7:0] in_b_reg, in_b_next;
    logic       held_a_reg, held_a_next;
    logic [3:0] prev_reg, prev_next;
    logic       a2_out_reg, a2_out_next;
    logic       b2_out_reg, b2_out_next;
    logic [7:0] rdata_next;

    pph_pkg::pph_ctl2_mode_t a2_mode;
    pph_pkg::pph_ctl2_mode_t b2_mode;

    function automatic logic edge_hit(input logic prev, input logic now, input logic pos);
        edge_hit = pos ? (!prev && now) : (prev && !now);
    endfunction : edge_hit

    function automatic logic independent(input pph_pkg::pph_ctl2_mode_t m);
        independent = (m == pph_pkg::PPH_IND_NEG) || (m == pph_pkg::PPH_IND_POS);
    endfunction : independent

    logic       acc, wr_b, acc_b, acc_a_hs, wr_a_nh, acc_a_nh, rd_a_any;
    logic       ev_a1, ev_a2, ev_b1, ev_b2;
    logic [7:0] flag_clr, flag_set;
    logic [7:0] read_a, read_b;
    logic       latch_a_en, latch_b_en;

    always_comb begin
        a2_mode    = pph_pkg::pph_ctl2_mode_t'(ctl_reg[pph_pkg::LC_A2_LSB +: 3]);
        b2_mode    = pph_ctl2_b();
        acc        = ce && chip_sel && (rd_stb || wr_stb);
        acc_b      = acc && (reg_sel == pph_pkg::REG_PORT_B);
        wr_b       = acc_b && wr_stb;
        acc_a_hs   = acc && (reg_sel == pph_pkg::REG_PORT_A);
        acc_a_nh   = acc && (reg_sel == pph_pkg::REG_PORT_A_NH);
        wr_a_nh    = acc_a_nh && wr_stb;
        rd_a_any   = (acc_a_hs || acc_a_nh) && rd_stb;
        latch_a_en = aux_reg[pph_pkg::AUX_LATCH_A];
        latch_b_en = aux_reg[pph_pkg::AUX_LATCH_B];
        ev_a1      = edge_hit(prev_reg[3], a1_s, ctl_reg[pph_pkg::LC_A1_EDGE]);
        ev_b1      = edge_hit(prev_reg[1], b1_s, ctl_reg[pph_pkg::LC_B1_EDGE]);
        ev_a2      = !ctl_reg[pph_pkg::LC_A2_LSB+2] && edge_hit(prev_reg[2], a2_s, ctl_reg[pph_pkg::LC_A2_LSB+1]);
        ev_b2      = !ctl_reg[pph_pkg::LC_B2_LSB+2] && edge_hit(prev_reg[0], b2_s, ctl_reg[pph_pkg::LC_B2_LSB+1]);
        prev_next  = ce ? {a1_s, a2_s, b1_s, b2_s} : prev_reg;

        // Read values
        read_a = held_a_reg ? in_a_reg : pin_a;
        read_b = (dir_b_reg & out_b_reg) | (~dir_b_reg & (latch_b_en ? in_b_reg : pin_b));

        // Flags: hardware set wins over any clear in the same cycle
        flag_set           = '0;
        flag_set[pph_pkg::FLG_A1] = ev_a1;
        flag_set[pph_pkg::FLG_A2] = ev_a2;
        flag_set[pph_pkg::FLG_B1] = ev_b1;
        flag_set[pph_pkg::FLG_B2] = ev_b2;
        flag_clr           = '0;
        if (acc && wr_stb && (reg_sel == pph_pkg::REG_FLAGS)) begin
            flag_clr = wdata & pph_pkg::FLG_MASK;
        end
        if (acc_a_hs) begin
            flag_clr[pph_pkg::FLG_A1] = 1'b1;
            flag_clr[pph_pkg::FLG_A2] = flag_clr[pph_pkg::FLG_A2] | !independent(a2_mode);
        end
        if (acc_b) begin
            flag_clr[pph_pkg::FLG_B1] = 1'b1;
            flag_clr[pph_pkg::FLG_B2] = flag_clr[pph_pkg::FLG_B2] | !independent(b2_mode);
        end
        flag_next = (flag_reg & ~flag_clr) | flag_set;

        // Port A input capture and transparency
        in_a_next   = in_a_reg;
        held_a_next = held_a_reg;
        if (rd_a_any) begin
            held_a_next = 1'b0;
        end
        if (ev_a1 && latch_a_en) begin
            in_a_next   = pin_a;
            held_a_next = 1'b1;
        end
        if (!latch_a_en) begin
            held_a_next = 1'b0;
        end
        in_b_next = (ev_b1 && latch_b_en) ? pin_b : in_b_reg;

        // Register writes
        out_a_next = out_a_reg;
        out_b_next = out_b_reg;
        dir_a_next = dir_a_reg;
        dir_b_next = dir_b_reg;
        aux_next   = aux_reg;
        ctl_next   = ctl_reg;
        if (acc && wr_stb) begin
            if (reg_sel == pph_pkg::REG_PORT_B) begin
                out_b_next = wdata;
            end else if (reg_sel == pph_pkg::REG_PORT_A || reg_sel == pph_pkg::REG_PORT_A_NH) begin
                out_a_next = wdata;
            end else if (reg_sel == pph_pkg::REG_DIR_B) begin
                dir_b_next = wdata;
            end else if (reg_sel == pph_pkg::REG_DIR_A) begin
                dir_a_next = wdata;
            end else if (reg_sel == pph_pkg::REG_AUX_CTRL) begin
                aux_next = wdata;
            end else if (reg_sel == pph_pkg::REG_LINE_CTRL) begin
                ctl_next = wdata;
            end
        end

        // Read data; unmapped registers read zero, rdata holds its value when the block is not selected
        rdata_next = rdata;
        if (acc && rd_stb) begin
            if (reg_sel == pph_pkg::REG_PORT_B) begin
                rdata_next = read_b;
            end else if (reg_sel == pph_pkg::REG_PORT_A || reg_sel == pph_pkg::REG_PORT_A_NH) begin
                rdata_next = read_a;
            end else if (reg_sel == pph_pkg::REG_DIR_B) begin
                rdata_next = dir_b_reg;
            end else if (reg_sel == pph_pkg::REG_DIR_A) begin
                rdata_next = dir_a_reg;
            end else if (reg_sel == pph_pkg::REG_AUX_CTRL) begin
                rdata_next = aux_reg;
            end else if (reg_sel == pph_pkg::REG_LINE_CTRL) begin
                rdata_next = ctl_reg;
            end else if (reg_sel == pph_pkg::REG_FLAGS) begin
                rdata_next = flag_reg;
            end else begin
                rdata_next = pph_pkg::RST_BYTE;
            end
        end

        // Port A second control line: read and write handshake
        a2_out_next = a2_out_reg;
        case (a2_mode)
            pph_pkg::PPH_OUT_HS: begin
                if (acc_a_hs) begin
                    a2_out_next = 1'b0;
                end else if (ev_a1) begin
                    a2_out_next = 1'b1;
                end
            end
            pph_pkg::PPH_OUT_PULSE: begin
                a2_out_next = !acc_a_hs;
            end
            pph_pkg::PPH_OUT_LOW:  a2_out_next = 1'b0;
            pph_pkg::PPH_OUT_HIGH: a2_out_next = 1'b1;
            default:               a2_out_next = 1'b1;
        endcase

        // Port B second control line: write handshake only
        b2_out_next = b2_out_reg;
        case (b2_mode)
            pph_pkg::PPH_OUT_HS: begin
                if (wr_b) begin
                    b2_out_next = 1'b0;
                end else if (ev_b1) begin
                    b2_out_next = 1'b1;
                end
            end
            pph_pkg::PPH_OUT_PULSE: begin
                b2_out_next = !wr_b;
            end
            pph_pkg::PPH_OUT_LOW:  b2_out_next = 1'b0;
            pph_pkg::PPH_OUT_HIGH: b2_out_next = 1'b1;
            default:               b2_out_next = 1'b1;
        endcase
    end

    function automatic pph_pkg::pph_ctl2_mode_t pph_ctl2_b();
        pph_ctl2_b = pph_pkg::pph_ctl2_mode_t'(ctl_reg[pph_pkg::LC_B2_LSB +: 3]);
    endfunction : pph_ctl2_b

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_a_reg  <= pph_pkg::RST_BYTE;
            out_b_reg  <= pph_pkg::RST_BYTE;
            dir_a_reg  <= pph_pkg::RST_BYTE;
            dir_b_reg  <= pph_pkg::RST_BYTE;
            aux_reg    <= pph_pkg::RST_BYTE;
            ctl_reg    <= pph_pkg::RST_BYTE;
            flag_reg   <= pph_pkg::RST_BYTE;
            in_a_reg   <= pph_pkg::RST_BYTE;
            in_b_reg   <= pph_pkg::RST_BYTE;
            held_a_reg <= 1'b0;
            prev_reg   <= 4'h0;
            a2_out_reg <= 1'b1;
            b2_out_reg <= 1'b1;
            rdata      <= pph_pkg::RST_BYTE;
        end else if (ce) begin
            out_a_reg  <= out_a_next;
            out_b_reg  <= out_b_next;
            dir_a_reg  <= dir_a_next;
            dir_b_reg  <= dir_b_next;
            aux_reg    <= aux_next;
            ctl_reg    <= ctl_next;
            flag_reg   <= flag_next;
            in_a_reg   <= in_a_next;
            in_b_reg   <= in_b_next;
            held_a_reg <= held_a_next;
            prev_reg   <= prev_next;
            a2_out_reg <= a2_out_next;
            b2_out_reg <= b2_out_next;
            rdata      <= rdata_next;
        end
    end

    // Pin drive: an input line keeps its stored value off the pin
    assign port_a_lines_o     = out_a_reg;
    assign port_a_lines_oe    = dir_a_reg;
    assign port_b_lines_o     = out_b_reg;
    assign port_b_lines_oe    = dir_b_reg;
    assign port_a_ctrl_two_o  = a2_out_reg;
    assign port_a_ctrl_two_oe = ctl_reg[pph_pkg::LC_A2_LSB+2];
    assign port_b_ctrl_two_o  = b2_out_reg;
    assign port_b_ctrl_two_oe = ctl_reg[pph_pkg::LC_B2_LSB+2];
    assign interrupt_flags    = flag_reg;

    // Queue of port A captures so a burst of data-ready edges survives a slow reader
    pph_fifo #(.W(pph_pkg::DATA_W), .DEPTH(pph_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_valid  (ev_a1 && latch_a_en),
        .in_ready  (capture_ready),
        .in_data   (pin_a),
        .out_valid (capture_valid),
        .out_ready (capture_take),
        .out_data  (capture_data)
    );
endmodule : pph_ports

// ---- bench/pph_ports_props.sv ----
// Checker: bus, pin and control-line relations at the pph_ports boundary
`timescale 1ns/10ps
module pph_ports_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       ce,
    input wire logic       chip_sel,
    input wire logic [3:0] reg_sel,
    input wire logic       rd_stb,
    input wire logic       wr_stb,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [7:0] port_b_lines_o,
    input wire logic [7:0] port_b_lines_oe,
    input wire logic       port_a_ctrl_two_o,
    input wire logic       port_b_ctrl_one,
    input wire logic       port_b_ctrl_two_o,
    input wire logic       port_b_ctrl_two_oe,
    input wire logic [7:0] interrupt_flags
);
    logic [7:0] lc_reg;
    logic [7:0] lc_next;
    logic       rd;
    logic       wr;
    logic [2:0] mb;
    assign rd = ce & chip_sel & rd_stb;
    assign wr = ce & chip_sel & wr_stb;
    assign mb = lc_reg[7:5];
    // Shadow of line control, so mode-dependent behaviour can be judged from the ports alone
    always_comb begin
        lc_next = lc_reg;
        if (wr && reg_sel == 4'hC) lc_next = wdata;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) lc_reg <= 8'h00;
        else lc_reg <= lc_next;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    dir_drive_a: assert property (wr && reg_sel == 4'h2 |=> port_b_lines_oe == $past(wdata))
        else $error("direction write not applied");
    out_store_a: assert property (wr && reg_sel == 4'h0 |=> port_b_lines_o == $past(wdata))
        else $error("output write not applied");
    b_readback_a: assert property (rd && reg_sel == 4'h0 |=>
        ((rdata ^ $past(port_b_lines_o)) & $past(port_b_lines_oe)) == 8'h00) else $error("B readback wrong");
    pulse_width_a: assert property (wr && reg_sel == 4'h0 && mb == 3'h5 |=>
        !port_b_ctrl_two_o ##1 port_b_ctrl_two_o) else $error("pulse not one cycle");
    hs_low_a: assert property (wr && reg_sel == 4'h0 && mb == 3'h4 |=>
        !port_b_ctrl_two_o && !interrupt_flags[4]) else $error("handshake write not low");
    taken_flag_a: assert property (mb == 3'h4 && lc_reg[4] && !port_b_ctrl_two_o && $rose(port_b_ctrl_one)
        |-> ##[1:4] (interrupt_flags[4] && port_b_ctrl_two_o)) else $error("taken edge ignored");
    indep_keep_a: assert property (!mb[2] && mb[0] && interrupt_flags[3] && (rd || wr) && reg_sel == 4'h0
        |=> interrupt_flags[3]) else $error("independent flag cleared");
    fixed_level_a: assert property (mb[2:1] == 2'h3 && $stable(lc_reg) |-> port_b_ctrl_two_o == mb[0])
        else $error("fixed level wrong");
    mode_dir_a: assert property ($stable(lc_reg) |-> port_b_ctrl_two_oe == lc_reg[7])
        else $error("control two direction wrong");
    a_read_hs_a: assert property (rd && reg_sel == 4'h1 && lc_reg[3:1] == 3'h4 |=> !port_a_ctrl_two_o)
        else $error("read did not signal taken");
    no_hs_reg_a: assert property (interrupt_flags[1] && (rd || wr) && reg_sel == 4'hF |=> interrupt_flags[1])
        else $error("no-handshake access cleared flag");
    c_pulse: cover property (wr && reg_sel == 4'h0 && mb == 3'h5);
    c_taken: cover property ($rose(interrupt_flags[4]));
    c_indep: cover property (mb == 3'h3 && interrupt_flags[3]);
endmodule : pph_ports_props

// ---- bench/pph_periph_model.sv ----
// Peripheral model: byte source on port A, write-handshake sink on port B
`timescale 1ns/10ps
module pph_periph_model (
    input  wire logic       clk,
    input  wire logic       rude,
    input  wire logic       slow,
    input  wire logic       b_en,
    input  wire logic       a_taken,
    input  wire logic       b_ready,
    input  wire logic [7:0] b_lines,
    output logic      [7:0] a_lines,
    output logic            a_ready,
    output logic            b_taken
);
    logic [7:0] b_got[$];
    initial begin
        a_lines = 8'h00;
        a_ready = 1'b0;
        b_taken = 1'b0;
    end
    task automatic send_a(input logic [7:0] v);
        int n;
        @(posedge clk) #1 a_lines = v;
        repeat (2) @(posedge clk);
        #1 a_ready = 1'b1;
        repeat (6) @(posedge clk);
        n = 0;
        // A rude source moves on without waiting, used to prove input latching and to fill the capture queue
        while (!rude && a_taken && n < 200) begin
            @(posedge clk);
            n++;
        end
        #1 a_lines = ~v;
        a_ready = 1'b0;
    endtask : send_a
    always @(posedge clk) begin
        if (b_en && !b_ready && !b_taken) begin
            b_got.push_back(b_lines);
            repeat (slow ? 6 : 1) @(posedge clk);
            #1 b_taken = 1'b1;
            repeat (4) @(posedge clk);
            #1 b_taken = 1'b0;
        end
    end
endmodule : pph_periph_model

// ---- bench/parallel_port_handshake_tb_top.sv ----
// Testbench: registers, pins, handshakes and capture buffer of pph_ports
`timescale 1ns/10ps
module parallel_port_handshake_tb_top;
    logic       clk = 1'b0, resetn = 1'b0, ce = 1'b1, chip_sel = 1'b0, rd_stb = 1'b0, wr_stb = 1'b0;
    logic       capture_take = 1'b0, rude = 1'b0, slow = 1'b0, b_en = 1'b0, a_src = 1'b0, tb_b2 = 1'b1;
    logic [3:0] reg_sel = 4'h0;
    logic [7:0] wdata = 8'h00, tb_pin = 8'h00, load = 8'h00, m_a, d, o;
    logic [7:0] rdata, port_a_lines_i, port_a_lines_o, port_a_lines_oe, port_b_lines_i, port_b_lines_o;
    logic [7:0] port_b_lines_oe, interrupt_flags, capture_data;
    logic       port_a_ctrl_one, port_b_ctrl_one, port_a_ctrl_two_i, port_a_ctrl_two_o, port_a_ctrl_two_oe;
    logic       port_b_ctrl_two_i, port_b_ctrl_two_o, port_b_ctrl_two_oe, capture_ready, capture_valid;
    logic [7:0] fq[$];
    int         seed = 32'h3e8110cc, bad_count = 0, total_checks = 0;
    // Output lines read back through a load that can flip them
    assign port_a_lines_i = (port_a_lines_oe & (port_a_lines_o ^ load)) | (~port_a_lines_oe & (a_src ? m_a : tb_pin));
    assign port_b_lines_i = (port_b_lines_oe & (port_b_lines_o ^ load)) | (~port_b_lines_oe & tb_pin);
    assign port_a_ctrl_two_i = port_a_ctrl_two_oe ? port_a_ctrl_two_o : 1'b1;
    assign port_b_ctrl_two_i = port_b_ctrl_two_oe ? port_b_ctrl_two_o : tb_b2;
    pph_ports dut (
        .clk, .resetn, .ce, .chip_sel, .reg_sel, .rd_stb, .wr_stb, .wdata, .rdata,
        .port_a_lines_i, .port_a_lines_o, .port_a_lines_oe, .port_b_lines_i, .port_b_lines_o,
        .port_b_lines_oe, .port_a_ctrl_one, .port_a_ctrl_two_i, .port_a_ctrl_two_o, .port_a_ctrl_two_oe,
        .port_b_ctrl_one, .port_b_ctrl_two_i, .port_b_ctrl_two_o, .port_b_ctrl_two_oe, .interrupt_flags,
        .capture_ready, .capture_valid, .capture_take, .capture_data
    );
    pph_periph_model peer (
        .clk, .rude, .slow, .b_en, .a_taken(port_a_ctrl_two_o), .b_ready(port_b_ctrl_two_o),
        .b_lines(port_b_lines_o), .a_lines(m_a), .a_ready(port_a_ctrl_one), .b_taken(port_b_ctrl_one)
    );
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [3:0] r, input logic w, input logic [7:0] v);
        @(posedge clk) #1 chip_sel = 1'b1;
        reg_sel = r;
        wr_stb = w;
        rd_stb = !w;
        wdata = v;
        @(posedge clk) #1 chip_sel = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    endtask : acc
    task automatic wait_flag(input logic [7:0] f);
        for (int n = 0; n < 100 && (interrupt_flags & f) !== f; n++) @(posedge clk) #1;
        #1;
    endtask : wait_flag
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            o = 8'($random(seed));
            tb_pin = 8'($random(seed));
            load = 8'($random(seed));
            acc(4'h2, 1'b1, d);
            acc(4'h3, 1'b1, ~d);
            acc(4'h0, 1'b1, o);
            acc(4'h1, 1'b1, ~o);
            repeat (3) @(posedge clk) #1;
            chk(port_b_lines_oe & port_b_lines_o, d & o);
            chk(port_b_lines_o, o);
            chk(port_a_lines_oe, ~d);
            acc(4'h0, 1'b0, 8'h00);
            chk(rdata, (d & o) | (~d & tb_pin));
            acc(4'hF, 1'b0, 8'h00);
            chk(rdata, (~d & (~o ^ load)) | (d & tb_pin));
            ce = 1'b0;
            acc(4'h0, 1'b1, ~o);
            ce = 1'b1;
            chk(port_b_lines_o, o);
        end
        for (int m = 0; m < 8; m++) begin
            acc(4'hC, 1'b1, {3'(m), 5'h10});
            tb_b2 = ~m[1];
            repeat (4) @(posedge clk);
            #1 chk({7'h00, port_b_ctrl_two_oe}, {7'h00, m[2]});
            if (m > 5) chk({7'h00, port_b_ctrl_two_o}, {7'h00, m[0]});
            if (m < 4) begin
                tb_b2 = m[1];
                wait_flag(8'h08);
                chk(interrupt_flags & 8'h08, 8'h08);
                acc(4'h0, 1'b1, 8'h00);
                chk(interrupt_flags & 8'h08, m[0] ? 8'h08 : 8'h00);
                acc(4'hD, 1'b1, 8'h08);
                chk(interrupt_flags & 8'h08, 8'h00);
            end
        end
        b_en = 1'b1;
        for (int k = 0; k < 4; k++) begin
            slow = k[0];
            acc(4'hC, 1'b1, {k[1] ? 3'h5 : 3'h4, 5'h10});
            o = 8'($random(seed));
            fq.push_back(o);
            acc(4'h0, 1'b1, o);
            wait_flag(8'h10);
            chk(interrupt_flags & 8'h10, 8'h10);
            chk({7'h00, port_b_ctrl_two_o}, 8'h01);
        end
        b_en = 1'b0;
        acc(4'hB, 1'b1, 8'h02);
        acc(4'h0, 1'b0, 8'h00);
        chk(rdata, d & o);
        chk(8'(peer.b_got.size()), 8'h04);
        while (fq.size() > 0) chk(peer.b_got.pop_front(), fq.pop_front());
        a_src = 1'b1;
        acc(4'h3, 1'b1, 8'h00);
        acc(4'hB, 1'b1, 8'h01);
        acc(4'hC, 1'b1, 8'h09);
        for (int k = 0; k < 33; k++) begin
            o = 8'($random(seed));
            if (fq.size() < 32) fq.push_back(o);
            rude = (k > 2);
            if (k == 1) acc(4'hC, 1'b1, 8'h0B);
            if (k == 3) acc(4'hC, 1'b1, 8'h01);
            fork
                peer.send_a(o);
            join_none
            wait_flag(8'h02);
            chk(interrupt_flags & 8'h02, 8'h02);
            if (k < 3) begin
                chk({7'h00, port_a_ctrl_two_o}, 8'h01);
                chk({7'h00, port_a_ctrl_two_oe}, 8'h01);
                acc(4'h1, 1'b0, 8'h00);
                chk(rdata, o);
                chk({7'h00, port_a_ctrl_two_o}, 8'h00);
            end
            wait fork;
            if (k == 3) begin
                repeat (3) @(posedge clk);
                acc(4'hF, 1'b0, 8'h00);
                chk(rdata, o);
                chk(interrupt_flags & 8'h02, 8'h02);
                acc(4'h1, 1'b0, 8'h00);
                chk(rdata, ~o);
            end
            acc(4'hD, 1'b1, 8'h02);
        end
        chk({7'h00, capture_ready}, 8'h00);
        while (fq.size() > 0) begin
            repeat (2'($random(seed))) @(posedge clk);
            @(posedge clk) #1 capture_take = 1'b1;
            chk(capture_data, fq.pop_front());
            @(posedge clk) #1 capture_take = 1'b0;
        end
        chk({7'h00, capture_valid}, 8'h00);
        finish_test();
    end
endmodule : parallel_port_handshake_tb_top
bind pph_ports pph_ports_props u_props (
    .clk, .resetn, .ce, .chip_sel, .reg_sel, .rd_stb, .wr_stb, .wdata, .rdata, .port_b_lines_o,
    .port_b_lines_oe, .port_a_ctrl_two_o, .port_b_ctrl_one, .port_b_ctrl_two_o, .port_b_ctrl_two_oe,
    .interrupt_flags
);
